// ===== hw/srpm_pkg.sv
//Contract
//- set low flag on selected threshold crossing
//- low flag with enable raises interrupt
//- comparator status shows above/below threshold
//- host port disabled for powerup delay
//- reset polarity bit selects active level
//- powerup reset holds extra delay after enable
//- external reset input low asserts, releases immediately
//- watchdog expiry asserts reset about 60 ms
//- sleep reset held, then hold delay
//- key 0x3C at 0x1F resets registers
//- select 6 with switch: floats in sleep
//- select 6 no switch: high sleep indication
//- wake trigger ORs all enabled requests
//- run state: no power removal, no sleep reset
//- sleep accepted only with valid wake source
//- wait state lasts count to count+1 ticks
//- trigger in wait returns run, clears request
//- timeout count zero sleeps directly
//- timeout enters sleep; trigger wakes to run
//- slept flag set on sleep entry
//- reject request when stopped or irq pending
`default_nettype none
package srpm_pkg;
	localparam logic [7:0] SRPM_KEY_ADDR = 8'h1F;
	localparam logic [7:0] SRPM_KEY_RESET = 8'h3C;
	localparam logic [7:0] SRPM_CTRL_ADDR = 8'h20;
	localparam logic [7:0] SRPM_STAT_ADDR = 8'h21;
	localparam logic [7:0] SRPM_SLEEP_ADDR = 8'h22;
	localparam logic [7:0] SRPM_EN_ADDR = 8'h23;
	localparam logic [7:0] SRPM_CTRL_RST = 8'h1C; // pin2 on fixed low drive, reset active low
	localparam logic [2:0] SRPM_PIN2_SLEEP = 3'h6;
	localparam logic [2:0] SRPM_PIN2_RST = 3'h7;
	localparam int SRPM_CLK_HZ = 10000000;
	localparam int SRPM_TICK_MS = 8;
	localparam int SRPM_POWERUP_IO_DELAY_MS = 300;
	localparam int SRPM_WDRST_MS = 60;
	localparam int SRPM_HOLD_MS = 200;
	localparam int SRPM_TICK_CYC = SRPM_CLK_HZ / 1000 * SRPM_TICK_MS;
	localparam int SRPM_POWERUP_IO_DELAY_CYC = SRPM_CLK_HZ / 1000 * SRPM_POWERUP_IO_DELAY_MS;
	localparam int SRPM_WDRST_CYC = SRPM_CLK_HZ / 1000 * SRPM_WDRST_MS;
	localparam int SRPM_HOLD_CYC = SRPM_CLK_HZ / 1000 * SRPM_HOLD_MS;
	typedef enum logic [1:0] {SRPM_RUN, SRPM_WAIT, SRPM_SLEEP} srpm_state_t;
endpackage : srpm_pkg
`default_nettype wire

// ===== hw/srpm_top.sv
`default_nettype none
module srpm_top import srpm_pkg::*; #(
	parameter int TICK_CYC = SRPM_TICK_CYC,
	parameter int POWERUP_IO_DELAY_CYC = SRPM_POWERUP_IO_DELAY_CYC,
	parameter int WDRST_CYC = SRPM_WDRST_CYC,
	parameter int HOLD_CYC = SRPM_HOLD_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic power_valid,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic host_io_en,
	input wire logic vbat_above_fall,
	input wire logic vbat_above_rise,
	input wire logic ext_reset_in,
	input wire logic wdt_expire,
	input wire logic [6:0] irq_req,
	input wire logic stop_bit,
	output logic irq_out,
	output logic freq_out_irq_pin,
	output logic reset_out_pin,
	output logic power_switch_o,
	output logic power_switch_oe_n
);
	// ----------------------------------------
	// synchronisers
	// ----------------------------------------
	logic [3:0] s1_ff;
	logic [3:0] s2_ff;
	// only the watchdog line gets an edge detector here; the comparator edge is taken after the polarity select
	logic s3_ff;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_ff <= 4'hF;
			s2_ff <= 4'hF;
		end else begin
			s1_ff <= {vbat_above_fall, vbat_above_rise, ext_reset_in, wdt_expire};
			s2_ff <= s1_ff;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) s3_ff <= 1'b1;
		else s3_ff <= s2_ff[0];
	end
	wire logic ext_rst_s = s2_ff[1];
	wire logic wdt_rise = s2_ff[0] & ~s3_ff;
	// ----------------------------------------
	// registers
	// ----------------------------------------
	// ctrl: [0] polarity [1] rst pol [2:4] pin2 sel [5] switch en [6] ext en [7] wd sel
	// en: [0] vbat irq en [1] sleep rst en [2:4] timeout count [5] threshold sel
	logic [7:0] ctrl_ff;
	logic [7:0] en_ff;
	logic [6:0] wake_en_ff;
	logic vbat_low_flag_ff;
	logic sleep_request_ff;
	logic slept_flag_ff;
	srpm_state_t state_ff;
	logic sw_rst;
	logic valid_wr;
	wire logic vbat_cross_polarity = ctrl_ff[0];
	wire logic reset_out_polarity = ctrl_ff[1];
	wire logic [2:0] pin2_output_sel = ctrl_ff[4:2];
	wire logic power_switch_en = ctrl_ff[5];
	wire logic ext_reset_en = ctrl_ff[6];
	wire logic watchdog_reset_sel = ctrl_ff[7];
	wire logic vbat_low_irq_en = en_ff[0];
	wire logic sleep_reset_en = en_ff[1];
	wire logic [2:0] sleep_timeout_count = en_ff[4:2];
	wire logic vbat_threshold_sel = en_ff[5];
	wire logic vbat_above_threshold = vbat_cross_polarity ? s2_ff[2] : s2_ff[3];
	wire logic [6:0] pend = {irq_req[6:1], vbat_low_flag_ff};
	wire logic wake_trigger = |(pend & wake_en_ff);
	wire logic wake_source_valid = |wake_en_ff[6:1];
	assign valid_wr = reg_wr & host_io_en;
	assign sw_rst = valid_wr && reg_addr == SRPM_KEY_ADDR && reg_wdata == SRPM_KEY_RESET;
	always_ff @(posedge clk) begin
		if (!rst_n || sw_rst) begin
			ctrl_ff <= SRPM_CTRL_RST;
			en_ff <= 8'h00;
			wake_en_ff <= 7'h00;
		end else if (valid_wr) begin
			if (reg_addr == SRPM_CTRL_ADDR) ctrl_ff <= reg_wdata;
			else if (reg_addr == SRPM_EN_ADDR) begin
				en_ff <= reg_wdata;
				wake_en_ff <= {reg_wdata[7:2] & 6'h3F, reg_wdata[0]};
			end
		end
	end
	// ----------------------------------------
	// comparator flag
	// ----------------------------------------
	logic above_d_ff;
	always_ff @(posedge clk) begin
		if (!rst_n) above_d_ff <= 1'b1;
		else above_d_ff <= vbat_above_threshold;
	end
	wire logic vbat_cross = vbat_cross_polarity ? (vbat_above_threshold & ~above_d_ff)
		: (~vbat_above_threshold & above_d_ff);
	wire logic flag_clr = valid_wr && reg_addr == SRPM_STAT_ADDR && !reg_wdata[0];
	always_ff @(posedge clk) begin
		if (!rst_n || sw_rst) vbat_low_flag_ff <= 1'b0;
		else if (vbat_cross) vbat_low_flag_ff <= 1'b1;
		else if (flag_clr) vbat_low_flag_ff <= 1'b0;
	end
	always_ff @(posedge clk) begin
		if (!rst_n) irq_out <= 1'b0;
		else irq_out <= vbat_low_flag_ff & vbat_low_irq_en;
	end
	// ----------------------------------------
	// power-up delay
	// ----------------------------------------
	logic [23:0] pu_cnt_ff;
	always_ff @(posedge clk) begin
		if (!rst_n || !power_valid) begin
			pu_cnt_ff <= 24'h000000;
			host_io_en <= 1'b0;
		end else if (!host_io_en) begin
			if (pu_cnt_ff == 24'(POWERUP_IO_DELAY_CYC - 1)) host_io_en <= 1'b1;
			pu_cnt_ff <= pu_cnt_ff + 24'h000001;
		end
	end
	assign freq_out_irq_pin = host_io_en;
	// ----------------------------------------
	// sleep state machine
	// ----------------------------------------
	logic [23:0] tick_cnt_ff;
	logic [3:0] wait_cnt_ff;
	wire logic tick = tick_cnt_ff == 24'(TICK_CYC - 1);
	always_ff @(posedge clk) begin
		if (!rst_n || tick) tick_cnt_ff <= 24'h000000;
		else tick_cnt_ff <= tick_cnt_ff + 24'h000001;
	end
	wire logic slp_wr = valid_wr && reg_addr == SRPM_SLEEP_ADDR;
	wire logic slp_ok = slp_wr && reg_wdata[7] && wake_source_valid
		&& !stop_bit && !(|pend);
	always_ff @(posedge clk) begin
		if (!rst_n || !power_valid || sw_rst) begin
			state_ff <= SRPM_RUN;
			sleep_request_ff <= 1'b0;
			wait_cnt_ff <= 4'h0;
		end else begin
			case (state_ff)
				SRPM_RUN: begin
					sleep_request_ff <= 1'b0;
					if (slp_ok) begin
						sleep_request_ff <= 1'b1;
						wait_cnt_ff <= {1'b0, sleep_timeout_count} + 4'h1;
						if (sleep_timeout_count == 3'h0) state_ff <= SRPM_SLEEP;
						else state_ff <= SRPM_WAIT;
					end
				end
				SRPM_WAIT: begin
					if (wake_trigger) begin
						state_ff <= SRPM_RUN;
						sleep_request_ff <= 1'b0;
					end else if (tick) begin
						wait_cnt_ff <= wait_cnt_ff - 4'h1;
						if (wait_cnt_ff == 4'h1) state_ff <= SRPM_SLEEP;
					end
				end
				SRPM_SLEEP: begin
					if (wake_trigger) begin
						state_ff <= SRPM_RUN;
						sleep_request_ff <= 1'b0;
					end
				end
				default: state_ff <= SRPM_RUN;
			endcase
		end
	end
	wire logic sleep_entry = state_ff != SRPM_SLEEP
		&& ((state_ff == SRPM_WAIT && tick && wait_cnt_ff == 4'h1 && !wake_trigger)
		|| (state_ff == SRPM_RUN && slp_ok && sleep_timeout_count == 3'h0));
	always_ff @(posedge clk) begin
		if (!rst_n || sw_rst) slept_flag_ff <= 1'b0;
		else if (sleep_entry) slept_flag_ff <= 1'b1;
		else if (slp_wr && !reg_wdata[6]) slept_flag_ff <= 1'b0;
	end
	wire logic in_sleep = state_ff == SRPM_SLEEP;
	// ----------------------------------------
	// reset generator
	// ----------------------------------------
	logic [23:0] hold_cnt_ff;
	logic [23:0] wd_cnt_ff;
	logic sleep_d_ff;
	logic io_d_ff;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sleep_d_ff <= 1'b0;
			io_d_ff <= 1'b0;
		end else begin
			sleep_d_ff <= in_sleep & sleep_reset_en;
			io_d_ff <= host_io_en;
		end
	end
	wire logic hold_start = (host_io_en & ~io_d_ff)
		| (sleep_d_ff & ~(in_sleep & sleep_reset_en));
	always_ff @(posedge clk) begin
		if (!rst_n || !power_valid) hold_cnt_ff <= 24'h000000;
		else if (hold_start) hold_cnt_ff <= 24'(HOLD_CYC);
		else if (hold_cnt_ff != 24'h000000) hold_cnt_ff <= hold_cnt_ff - 24'h000001;
	end
	always_ff @(posedge clk) begin
		if (!rst_n || !power_valid) wd_cnt_ff <= 24'h000000;
		else if (wdt_rise && watchdog_reset_sel) wd_cnt_ff <= 24'(WDRST_CYC);
		else if (wd_cnt_ff != 24'h000000) wd_cnt_ff <= wd_cnt_ff - 24'h000001;
	end
	wire logic rst_active = !host_io_en || hold_start || hold_cnt_ff != 24'h000000
		|| (ext_reset_en && !ext_rst_s)
		|| wd_cnt_ff != 24'h000000
		|| (in_sleep && sleep_reset_en);
	assign reset_out_pin = rst_active ^ ~reset_out_polarity;
	// ----------------------------------------
	// power switch pin and read-back
	// ----------------------------------------
	always_comb begin
		power_switch_o = 1'b0;
		power_switch_oe_n = 1'b0;
		if (pin2_output_sel == SRPM_PIN2_SLEEP) begin
			if (power_switch_en) power_switch_oe_n = in_sleep;
			else power_switch_o = in_sleep;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) reg_rdata <= 8'h00;
		else if (reg_rd) begin
			if (reg_addr == SRPM_CTRL_ADDR) reg_rdata <= ctrl_ff;
			else if (reg_addr == SRPM_EN_ADDR) reg_rdata <= en_ff;
			else if (reg_addr == SRPM_STAT_ADDR)
				reg_rdata <= {6'h00, vbat_above_threshold, vbat_low_flag_ff};
			else if (reg_addr == SRPM_SLEEP_ADDR)
				reg_rdata <= {sleep_request_ff, slept_flag_ff, 4'h0, state_ff};
			else reg_rdata <= 8'h00;
		end
	end
	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_run_no_power: assert property (@(posedge clk) disable iff (!rst_n)
		state_ff == SRPM_RUN |-> !(power_switch_en && power_switch_oe_n)) else $error("run cut");
	a_slept_entry: assert property (@(posedge clk) disable iff (!rst_n)
		sleep_entry && !sw_rst |=> slept_flag_ff) else $error("slept not set");
	a_zero_direct: assert property (@(posedge clk) disable iff (!rst_n || !power_valid)
		state_ff == SRPM_RUN && slp_ok && sleep_timeout_count == 3'h0 && !sw_rst
		|=> state_ff == SRPM_SLEEP) else $error("no direct sleep");
	a_wait_wake: assert property (@(posedge clk) disable iff (!rst_n || !power_valid)
		state_ff == SRPM_WAIT && wake_trigger && !sw_rst
		|=> state_ff == SRPM_RUN && !sleep_request_ff) else $error("wait wake");
	a_reject_stop: assert property (@(posedge clk) disable iff (!rst_n)
		state_ff == SRPM_RUN && stop_bit |=> !sleep_request_ff) else $error("stop ignored");
	a_irq_raise: assert property (@(posedge clk) disable iff (!rst_n)
		vbat_low_flag_ff && vbat_low_irq_en |=> irq_out) else $error("irq missing");
	a_io_gate: assert property (@(posedge clk) disable iff (!rst_n)
		!power_valid |=> !host_io_en && !freq_out_irq_pin) else $error("io open");
	a_rst_pol: assert property (@(posedge clk) disable iff (!rst_n)
		!host_io_en |-> reset_out_pin == reset_out_polarity) else $error("polarity");
	a_ext_rst: assert property (@(posedge clk) disable iff (!rst_n)
		ext_reset_en && !ext_rst_s |-> reset_out_pin == reset_out_polarity) else $error("ext");
	c_sleep: cover property (@(posedge clk) disable iff (!rst_n) sleep_entry);
	c_wait: cover property (@(posedge clk) disable iff (!rst_n) state_ff == SRPM_WAIT);
	a_pu_hold: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(host_io_en) |-> reset_out_pin == reset_out_polarity)
		else $error("power-up hold gap");
	a_sleep_hold: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(in_sleep && sleep_reset_en) |-> reset_out_pin == reset_out_polarity)
		else $error("sleep hold gap");
	a_sleep_float: assert property (@(posedge clk) disable iff (!rst_n)
		in_sleep && pin2_output_sel == SRPM_PIN2_SLEEP && power_switch_en |-> power_switch_oe_n)
		else $error("switch not open");
	a_sleep_pin: assert property (@(posedge clk) disable iff (!rst_n)
		pin2_output_sel == SRPM_PIN2_SLEEP && !power_switch_en
		|-> !power_switch_oe_n && power_switch_o == in_sleep) else $error("sleep pin");
	a_wd_hold: assert property (@(posedge clk) disable iff (!rst_n)
		wdt_rise && watchdog_reset_sel |=> reset_out_pin == reset_out_polarity)
		else $error("watchdog reset missing");
	a_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
		vbat_cross && !sw_rst |=> vbat_low_flag_ff)
		else $error("low flag not set");
	a_wait_bound: assert property (@(posedge clk) disable iff (!rst_n)
		state_ff == SRPM_WAIT |-> wait_cnt_ff != 4'h0 && wait_cnt_ff <= 4'h8)
		else $error("wait count out of range");
	a_power_loss: assert property (@(posedge clk) disable iff (!rst_n)
		!power_valid |=> state_ff == SRPM_RUN && !sleep_request_ff)
		else $error("power loss kept sleep");
	a_wake_trigger_wake: assert property (@(posedge clk) disable iff (!rst_n)
		in_sleep && wake_trigger |=> state_ff == SRPM_RUN)
		else $error("no wake from sleep");
	a_accept_valid: assert property (@(posedge clk) disable iff (!rst_n)
		state_ff == SRPM_RUN && !wake_source_valid |=> !sleep_request_ff)
		else $error("sleep without wake source");
	a_soft_quiet: assert property (@(posedge clk) disable iff (!rst_n)
		sw_rst && !rst_active && !wdt_rise && power_valid |=> !rst_active)
		else $error("soft reset drove reset");
	// ----------------------------------------
	// cover points
	// ----------------------------------------
	c_wake: cover property (@(posedge clk) disable iff (!rst_n)
		in_sleep && wake_trigger);
	c_direct: cover property (@(posedge clk) disable iff (!rst_n)
		state_ff == SRPM_RUN && slp_ok && sleep_timeout_count == 3'h0);
	c_hold_end: cover property (@(posedge clk) disable iff (!rst_n)
		hold_cnt_ff == 24'h000001);
endmodule : srpm_top
`default_nettype wire

// ===== sim/srpm_host_model.sv
`default_nettype none
module srpm_host_model (
	input wire logic psw_o,
	input wire logic psw_oe_n,
	input wire logic ready_pin,
	output logic powered,
	output logic may_access
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// host supply return through the switch
	// ----------------------------------------
	// a released switch floats the host ground: count it as unpowered, never as a stale low
	assign powered = !psw_oe_n && (psw_o === 1'h0);
	// host polls the ready pin before its first access
	assign may_access = powered && (ready_pin === 1'h1);
endmodule : srpm_host_model
`default_nettype wire

// ===== sim/tb_top.sv
`default_nettype none
module tb_top;
	import srpm_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// bench signals
	// ----------------------------------------
	// short counts keep the run small; the power-up, watchdog, hold and sleep waits derive from these
	localparam int TK = 10, PU = 50, WD = 20, HD = 15;
	logic clk, rst_n, power_valid, reg_wr, reg_rd, vbat_above_fall, vbat_above_rise;
	logic ext_reset_in, wdt_expire, stop_bit, host_io_en, irq_out, freq_out_irq_pin;
	logic reset_out_pin, power_switch_o, power_switch_oe_n, powered, may_access;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic [6:0] irq_req;
	int n_mismatch = 0, num_checks = 0, cyc = 0;
	srpm_top #(.TICK_CYC(TK), .POWERUP_IO_DELAY_CYC(PU), .WDRST_CYC(WD), .HOLD_CYC(HD)) srpm_top_inst (
		.clk(clk), .rst_n(rst_n), .power_valid(power_valid), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.host_io_en(host_io_en), .vbat_above_fall(vbat_above_fall),
		.vbat_above_rise(vbat_above_rise), .ext_reset_in(ext_reset_in),
		.wdt_expire(wdt_expire), .irq_req(irq_req), .stop_bit(stop_bit), .irq_out(irq_out),
		.freq_out_irq_pin(freq_out_irq_pin), .reset_out_pin(reset_out_pin),
		.power_switch_o(power_switch_o), .power_switch_oe_n(power_switch_oe_n));
	srpm_host_model srpm_host_model_inst (.psw_o(power_switch_o),
		.psw_oe_n(power_switch_oe_n), .ready_pin(freq_out_irq_pin),
		.powered(powered), .may_access(may_access));
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			results();
		end
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : results
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc_n(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc_n
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk);
		reg_wr = 1'h1;
		reg_addr = a;
		reg_wdata = v;
		@(negedge clk);
		reg_wr = 1'h0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(negedge clk);
		reg_rd = 1'h1;
		reg_addr = a;
		@(negedge clk);
		reg_rd = 1'h0;
		@(negedge clk);
		d = reg_rdata;
	endtask : rd
	task automatic slp_req();
		wr(SRPM_SLEEP_ADDR, 8'h80);
		rd(SRPM_SLEEP_ADDR);
	endtask : slp_req
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_powerup();
		cyc_n(PU - 5);
		chk(host_io_en, 1'h0);
		chk(freq_out_irq_pin, 1'h0);
		chk(reset_out_pin, 1'h0);
		for (int i = 0; i < 20 && host_io_en !== 1'h1; i++) @(negedge clk);
		chk(freq_out_irq_pin, 1'h1);
		cyc_n(HD - 3);
		chk(reset_out_pin, 1'h0);
		cyc_n(6);
		chk(reset_out_pin, 1'h1);
		chk(may_access, 1'h1);
	endtask : t_powerup
	task automatic t_resets();
		wr(SRPM_CTRL_ADDR, 8'h40);
		cyc_n(2);
		chk(reset_out_pin, 1'h1);
		ext_reset_in = 1'h0;
		cyc_n(5);
		chk(reset_out_pin, 1'h0);
		ext_reset_in = 1'h1;
		cyc_n(4);
		chk(reset_out_pin, 1'h1);
		wr(SRPM_CTRL_ADDR, 8'h42);
		ext_reset_in = 1'h0;
		cyc_n(5);
		chk(reset_out_pin, 1'h1);
		ext_reset_in = 1'h1;
		cyc_n(4);
		chk(reset_out_pin, 1'h0);
		wr(SRPM_CTRL_ADDR, 8'hC0);
		ext_reset_in = 1'h0;
		wdt_expire = 1'h1;
		cyc_n(10);
		ext_reset_in = 1'h1;
		cyc_n(5);
		chk(reset_out_pin, 1'h0);
		cyc_n(WD);
		chk(reset_out_pin, 1'h1);
		wdt_expire = 1'h0;
	endtask : t_resets
	task automatic t_vbat();
		wr(SRPM_EN_ADDR, 8'h01);
		wr(SRPM_STAT_ADDR, 8'h00);
		rd(SRPM_STAT_ADDR);
		chk(d[1:0], 2'h2);
		vbat_above_fall = 1'h0;
		cyc_n(6);
		chk(irq_out, 1'h1);
		rd(SRPM_STAT_ADDR);
		chk(d[1:0], 2'h1);
		wr(SRPM_CTRL_ADDR, 8'h01);
		wr(SRPM_STAT_ADDR, 8'h00);
		rd(SRPM_STAT_ADDR);
		chk(d[1:0], 2'h0);
		vbat_above_rise = 1'h1;
		cyc_n(6);
		rd(SRPM_STAT_ADDR);
		chk(d[1:0], 2'h3);
		wr(SRPM_STAT_ADDR, 8'h00);
		cyc_n(3);
		chk(irq_out, 1'h0);
	endtask : t_vbat
	task automatic t_refuse();
		wr(SRPM_EN_ADDR, 8'h04);
		stop_bit = 1'h1;
		slp_req();
		chk(d[7], 1'h0);
		stop_bit = 1'h0;
		irq_req = 7'h02;
		slp_req();
		chk(d[7], 1'h0);
		irq_req = 7'h00;
		wr(SRPM_EN_ADDR, 8'h00);
		slp_req();
		chk(d[7], 1'h0);
	endtask : t_refuse
	task automatic t_sleep();
		wr(SRPM_CTRL_ADDR, 8'h38);
		wr(SRPM_SLEEP_ADDR, 8'h00);
		wr(SRPM_STAT_ADDR, 8'h00);
		wr(SRPM_EN_ADDR, 8'h06);
		slp_req();
		chk(d & 8'hC3, 8'h81);
		cyc_n(2 * TK + 2);
		rd(SRPM_SLEEP_ADDR);
		chk(d & 8'h43, 8'h42);
		chk(powered, 1'h0);
		chk(reset_out_pin, 1'h0);
		irq_req = 7'h02;
		cyc_n(4);
		chk(powered, 1'h1);
		chk(reset_out_pin, 1'h0);
		irq_req = 7'h00;
		cyc_n(HD + 2);
		chk(reset_out_pin, 1'h1);
		rd(SRPM_SLEEP_ADDR);
		chk(d & 8'hC3, 8'h40);
	endtask : t_sleep
	task automatic t_direct();
		wr(SRPM_CTRL_ADDR, 8'h18);
		wr(SRPM_SLEEP_ADDR, 8'h00);
		wr(SRPM_EN_ADDR, 8'h20);
		slp_req();
		chk(d & 8'h43, 8'h42);
		chk(power_switch_o, 1'h1);
		chk(power_switch_oe_n, 1'h0);
		chk(reset_out_pin, 1'h1);
		irq_req = 7'h10;
		cyc_n(3);
		irq_req = 7'h00;
		chk(power_switch_o, 1'h0);
	endtask : t_direct
	task automatic t_softreset();
		wr(SRPM_KEY_ADDR, SRPM_KEY_RESET);
		cyc_n(2);
		chk(reset_out_pin, 1'h1);
		rd(SRPM_EN_ADDR);
		chk(d, 8'h00);
		rd(SRPM_CTRL_ADDR);
		chk(d, SRPM_CTRL_RST);
	endtask : t_softreset
	task automatic t_wait_wake();
		wr(SRPM_EN_ADDR, 8'h1C);
		slp_req();
		chk(d & 8'h83, 8'h81);
		irq_req = 7'h08;
		cyc_n(2);
		irq_req = 7'h00;
		rd(SRPM_SLEEP_ADDR);
		chk(d & 8'h83, 8'h00);
		slp_req();
		power_valid = 1'h0;
		cyc_n(3);
		power_valid = 1'h1;
		rd(SRPM_SLEEP_ADDR);
		chk(d & 8'h83, 8'h00);
	endtask : t_wait_wake
	initial begin
		rst_n = 1'h0;
		power_valid = 1'h1;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		vbat_above_fall = 1'h1;
		vbat_above_rise = 1'h0;
		ext_reset_in = 1'h1;
		wdt_expire = 1'h0;
		irq_req = 7'h00;
		stop_bit = 1'h0;
		cyc_n(8);
		rst_n = 1'h1;
		t_powerup();
		t_resets();
		t_vbat();
		t_refuse();
		t_sleep();
		t_direct();
		t_softreset();
		t_wait_wake();
		results();
	end
endmodule : tb_top
`default_nettype wire
